// *** include/float_cfg_params.svh ***
// Constants for the float-mode pulse configuration registers.
`ifndef FLOAT_CFG_PARAMS_SVH
`define FLOAT_CFG_PARAMS_SVH
`define ADDR_FLOAT_CFG_B 8'h59
`define ADDR_FIRE_MASKS 8'h5A
`define ADDR_FLOAT_CFG_A 8'h5E
`define RST_FLOAT_CFG 16'h0808
`define RST_FIRE_MASKS 16'h0010
`define FLOAT_EN_HI 14
`define FLOAT_EN_LO 13
`define PRECON_HI 12
`define PRECON_LO 8
`define FIRE_B_HI 15
`define FIRE_B_LO 12
`define FIRE_A_HI 11
`define FIRE_A_LO 8
`define FLOAT_EN_ON 2'h3
`define PULSE_STEP_NS 1000
`define CLOCK_PERIOD_NS 40
`define TICKS_PER_US (`PULSE_STEP_NS / `CLOCK_PERIOD_NS)
`endif

// *** include/float_cfg_pkg.sv ***
// Types shared by the float-mode pulse configuration design.
package float_cfg_pkg;
	typedef enum logic [0:0] {
		PULSE_IDLE = 1'b0,
		PULSE_DRIVE = 1'b1
	} pulse_state_e;
	typedef logic [15:0] cfg_word_t;
endpackage

// *** hw/pulse_fire_gate.sv ***
// Per-slot pulse gate: applies the fire pattern, times the LED pulse and picks the sample sign.
`timescale 1ns/1ns
`default_nettype none
`include "float_cfg_params.svh"
module pulse_fire_gate #(
	parameter int WIDTH_W = 5,
	parameter int TICKS_PER_US = `TICKS_PER_US
) (
	input wire logic clock,
	input wire logic sys_rst,
	input wire logic slot_start,
	input wire logic pulse_req,
	input wire logic [3:0] fire_pattern,
	input wire logic [WIDTH_W-1:0] pulse_width,
	input wire logic [3:0] pair_control,
	output logic led_drive,
	output logic sample_subtract,
	output logic [1:0] pulse_pos
);
	localparam int CNT_W = $clog2((2 ** WIDTH_W) * TICKS_PER_US + 1);
	float_cfg_pkg::pulse_state_e state_r;
	logic [CNT_W-1:0] cnt_r;
	logic take;
	logic fire;
	logic [CNT_W-1:0] load_cnt;

	// A pulse slot is only taken while idle; requests during a drive are ignored.
	assign take = pulse_req && (state_r == float_cfg_pkg::PULSE_IDLE) && !slot_start;
	assign fire = !fire_pattern[pulse_pos];
	// Width is in whole microseconds, so one count spans TICKS_PER_US clocks.
	assign load_cnt = CNT_W'(pulse_width * TICKS_PER_US - 1);

	// Position within the group of four wraps so the pattern repeats cyclically.
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			pulse_pos <= 2'h0;
		end else if (slot_start) begin
			pulse_pos <= 2'h0;
		end else if (take) begin
			pulse_pos <= pulse_pos + 2'h1;
		end
	end

	// A masked position still uses its slot but leaves the LED dark.
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			state_r <= float_cfg_pkg::PULSE_IDLE;
			led_drive <= 1'b0;
			cnt_r <= '0;
		end else begin
			case (state_r)
				float_cfg_pkg::PULSE_IDLE: begin
					if (take && fire && pulse_width != '0) begin
						state_r <= float_cfg_pkg::PULSE_DRIVE;
						led_drive <= 1'b1;
						cnt_r <= load_cnt;
					end
				end
				float_cfg_pkg::PULSE_DRIVE: begin
					if (cnt_r == '0) begin
						state_r <= float_cfg_pkg::PULSE_IDLE;
						led_drive <= 1'b0;
					end else begin
						cnt_r <= cnt_r - CNT_W'(1);
					end
				end
				default: begin
					state_r <= float_cfg_pkg::PULSE_IDLE;
					led_drive <= 1'b0;
				end
			endcase
		end
	end

	// Odd code bit governs the first pulse of a pair, even bit the second.
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			sample_subtract <= 1'b0;
		end else if (take) begin
			sample_subtract <= pair_control[{pulse_pos[1], ~pulse_pos[0]}];
		end
	end

	default clocking @(posedge clock); endclocking
	default disable iff (sys_rst);

	masked_stays_dark_a: assert property (take && fire_pattern[pulse_pos] |=> !led_drive)
		else $error("masked pulse lit the LED");
	fired_lights_led_a: assert property (take && !fire_pattern[pulse_pos] && pulse_width == WIDTH_W'(1)
		|=> led_drive [*8])
		else $error("fired pulse did not light the LED");
	one_us_width_a: assert property ($rose(led_drive) && cnt_r == CNT_W'(TICKS_PER_US - 1)
		|-> ##24 led_drive ##1 !led_drive)
		else $error("one microsecond pulse has wrong length");
	group_wraps_a: assert property (take && pulse_pos == 2'h3 |=> pulse_pos == 2'h0)
		else $error("pulse position did not wrap");
	sign_select_a: assert property (take
		|=> sample_subtract == $past(pair_control[{pulse_pos[1], ~pulse_pos[0]}]))
		else $error("sample sign mismatch");
	fired_cover_c: cover property (take && fire ##1 led_drive);
	masked_cover_c: cover property (take && !fire);
endmodule
`default_nettype wire

// *** hw/float_mode_pulse_config.sv ***
// Float-mode pulse configuration register bank with per-slot fire gating.
`timescale 1ns/1ns
`default_nettype none
`include "float_cfg_params.svh"
module float_mode_pulse_config #(
	parameter int WIDTH_W = 5
) (
	input wire logic clock,
	input wire logic sys_rst,
	input wire logic [7:0] reg_addr,
	input wire logic [15:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [15:0] reg_rdata,
	output logic reg_rvalid,
	input wire logic [1:0] slot_start,
	input wire logic [1:0] pulse_req,
	input wire logic [WIDTH_W-1:0] float_pulse_width_slot_a,
	input wire logic [WIDTH_W-1:0] float_pulse_width_slot_b,
	input wire logic [3:0] pair_sum_control_slot_a,
	input wire logic [3:0] pair_sum_control_slot_b,
	output logic float_active_a,
	output logic float_active_b,
	output logic [4:0] precondition_delay_slot_a,
	output logic [4:0] precondition_delay_slot_b,
	output logic [1:0] led_drive,
	output logic [1:0] sample_subtract
);
	float_cfg_pkg::cfg_word_t cfg_a_r;
	float_cfg_pkg::cfg_word_t cfg_b_r;
	float_cfg_pkg::cfg_word_t fire_r;
	float_cfg_pkg::cfg_word_t rdata_nxt;
	logic [1:0] float_enable_slot_a;
	logic [1:0] float_enable_slot_b;
	logic [3:0] pulse_fire_pattern_slot_a;
	logic [3:0] pulse_fire_pattern_slot_b;
	logic [3:0] pattern [2];
	logic [WIDTH_W-1:0] width_sel [2];
	logic [3:0] pair_sel [2];
	logic [1:0] pos_unused [2];
	logic addr_mapped;

	// Whole words are stored, reserved bits included, so a read returns what was written.
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			cfg_b_r <= `RST_FLOAT_CFG;
			fire_r <= `RST_FIRE_MASKS;
			cfg_a_r <= `RST_FLOAT_CFG;
		end else if (reg_wr) begin
			case (reg_addr)
				`ADDR_FLOAT_CFG_B: begin
					cfg_b_r <= reg_wdata;
				end
				`ADDR_FIRE_MASKS: begin
					fire_r <= reg_wdata;
				end
				`ADDR_FLOAT_CFG_A: begin
					cfg_a_r <= reg_wdata;
				end
				default: begin
				end
			endcase
		end
	end

	// Field views of the stored words.
	// The enable fields are not filtered here; the decode below decides what a reserved code means.
	assign float_enable_slot_b = cfg_b_r[`FLOAT_EN_HI:`FLOAT_EN_LO];
	assign float_enable_slot_a = cfg_a_r[`FLOAT_EN_HI:`FLOAT_EN_LO];
	assign pulse_fire_pattern_slot_b = fire_r[`FIRE_B_HI:`FIRE_B_LO];
	assign pulse_fire_pattern_slot_a = fire_r[`FIRE_A_HI:`FIRE_A_LO];
	assign precondition_delay_slot_b = cfg_b_r[`PRECON_HI:`PRECON_LO];
	assign precondition_delay_slot_a = cfg_a_r[`PRECON_HI:`PRECON_LO];

	// Reserved enable codes are treated as off, so a stray 1 or 2 never starts float mode.
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			float_active_a <= 1'b0;
			float_active_b <= 1'b0;
		end else begin
			float_active_b <= (float_enable_slot_b == `FLOAT_EN_ON);
			float_active_a <= (float_enable_slot_a == `FLOAT_EN_ON);
		end
	end

	// Read mux; unmapped addresses read as zero.
	always_comb begin
		case (reg_addr)
			`ADDR_FLOAT_CFG_B: rdata_nxt = cfg_b_r;
			`ADDR_FIRE_MASKS: rdata_nxt = fire_r;
			`ADDR_FLOAT_CFG_A: rdata_nxt = cfg_a_r;
			default: rdata_nxt = 16'h0000;
		endcase
	end

	// Decoded hit on one of the three stored words, shared by the unmapped-write and unmapped-read checks.
	assign addr_mapped = (reg_addr == `ADDR_FLOAT_CFG_B) || (reg_addr == `ADDR_FIRE_MASKS)
		|| (reg_addr == `ADDR_FLOAT_CFG_A);

	// Read data is held until the next read so the serial port can shift it out at leisure.
	// A read of an unmapped address still answers, with zeros, so the port never waits on it.
	always_ff @(posedge clock or posedge sys_rst) begin
		if (sys_rst) begin
			reg_rdata <= 16'h0000;
			reg_rvalid <= 1'b0;
		end else begin
			reg_rvalid <= reg_rd;
			if (reg_rd) begin
				reg_rdata <= rdata_nxt;
			end
		end
	end

	// Slot 0 is A and slot 1 is B on the per-slot vectors.
	// Keeping the pairing in one place means a swapped slot shows up in a single spot.
	assign pattern[0] = pulse_fire_pattern_slot_a;
	assign pattern[1] = pulse_fire_pattern_slot_b;
	assign width_sel[0] = float_pulse_width_slot_a;
	assign width_sel[1] = float_pulse_width_slot_b;
	assign pair_sel[0] = pair_sum_control_slot_a;
	assign pair_sel[1] = pair_sum_control_slot_b;

	// One gate per slot; the gate owns pulse position, width timing and sample sign.
	for (genvar s = 0; s < 2; s++) begin : g_slot
		pulse_fire_gate #(
			.WIDTH_W(WIDTH_W),
			.TICKS_PER_US(`TICKS_PER_US)
		) u_gate (
			.clock(clock),
			.sys_rst(sys_rst),
			.slot_start(slot_start[s]),
			.pulse_req(pulse_req[s]),
			.fire_pattern(pattern[s]),
			.pulse_width(width_sel[s]),
			.pair_control(pair_sel[s]),
			.led_drive(led_drive[s]),
			.sample_subtract(sample_subtract[s]),
			.pulse_pos(pos_unused[s])
		);
		// A slot start always brings the group back to its first pulse.
		slot_restart_a: assert property (@(posedge clock) disable iff (sys_rst)
			slot_start[s] |=> pos_unused[s] == 2'h0)
			else $error("slot start did not restart the group");
		// A lit LED always traces back to a firing bit at the position just taken.
		led_from_fire_a: assert property (@(posedge clock) disable iff (sys_rst)
			$rose(led_drive[s]) |-> !$past(pattern[s][pos_unused[s]]))
			else $error("LED lit on a masked position");
	end

	default clocking @(posedge clock); endclocking
	default disable iff (sys_rst);

	// Enable decode: each flag follows its stored code one cycle later.
	float_b_enable_a: assert property (float_active_b == ($past(cfg_b_r[14:13]) == 2'h3))
		else $error("slot B float enable decode wrong");
	float_a_enable_a: assert property (float_active_a == ($past(cfg_a_r[14:13]) == 2'h3))
		else $error("slot A float enable decode wrong");

	// Reserved codes must never start float mode, whatever the code was before.
	reserved_code_off_a: assert property (reg_wr && reg_addr == 8'h5E && reg_wdata[14:13] == 2'h1
		|=> ##1 !float_active_a)
		else $error("reserved enable code turned float on");
	reserved_b_off_a: assert property (reg_wr && reg_addr == `ADDR_FLOAT_CFG_B && reg_wdata[14:13] == 2'h2
		|=> ##1 !float_active_b)
		else $error("reserved enable code turned slot B float on");

	// Preconditioning delays are exposed straight from the stored words.
	precon_b_field_a: assert property (reg_wr && reg_addr == 8'h59
		|=> precondition_delay_slot_b == $past(reg_wdata[12:8]))
		else $error("slot B preconditioning field not written");
	precon_a_field_a: assert property (reg_wr && reg_addr == 8'h5E
		|=> precondition_delay_slot_a == $past(reg_wdata[12:8]))
		else $error("slot A preconditioning field not written");

	// Fire lanes: slot B owns the upper nibble, slot A the nibble below it.
	fire_b_lanes_a: assert property (reg_wr && reg_addr == 8'h5A
		|=> pulse_fire_pattern_slot_b == $past(reg_wdata[15:12]))
		else $error("slot B fire pattern in wrong bits");
	fire_a_lanes_a: assert property (reg_wr && reg_addr == 8'h5A
		|=> pulse_fire_pattern_slot_a == $past(reg_wdata[11:8]))
		else $error("slot A fire pattern in wrong bits");

	// A write lands only in the word it addresses, and nowhere at all when unmapped.
	b_write_only_a: assert property (reg_wr && reg_addr == `ADDR_FLOAT_CFG_B
		|=> $stable(cfg_a_r) && $stable(fire_r))
		else $error("slot B write disturbed another register");
	mask_write_only_a: assert property (reg_wr && reg_addr == `ADDR_FIRE_MASKS
		|=> $stable(cfg_a_r) && $stable(cfg_b_r))
		else $error("fire mask write disturbed another register");
	a_write_only_a: assert property (reg_wr && reg_addr == `ADDR_FLOAT_CFG_A
		|=> $stable(cfg_b_r) && $stable(fire_r))
		else $error("slot A write disturbed another register");
	unmapped_write_keeps_a: assert property (reg_wr && !addr_mapped
		|=> $stable(cfg_a_r) && $stable(cfg_b_r) && $stable(fire_r))
		else $error("unmapped write changed a register");

	// Read side: one-cycle valid, held data, and a word written to 0x59 comes back whole.
	write_readback_a: assert property (reg_wr && reg_addr == 8'h59 ##1 !reg_wr
		##1 reg_rd && reg_addr == 8'h59 && !reg_wr |=> reg_rvalid && reg_rdata == $past(reg_wdata, 3))
		else $error("read did not return written value");
	unmapped_zero_a: assert property (reg_rd && !addr_mapped |=> reg_rvalid && reg_rdata == 16'h0000)
		else $error("unmapped read not zero");
	rvalid_one_cycle_a: assert property (reg_rvalid == $past(reg_rd))
		else $error("read valid not one cycle after the strobe");
	rdata_holds_a: assert property (!reg_rd |=> $stable(reg_rdata))
		else $error("read data changed without a read");

	// Main scenarios: float turned on, a register read back, both slots lit together.
	float_on_cover_c: cover property (reg_wr && reg_addr == 8'h59 && reg_wdata[14:13] == 2'h3 ##2 float_active_b);
	readback_cover_c: cover property (reg_rd && reg_addr == 8'h5A ##1 reg_rvalid);
	both_fire_cover_c: cover property (led_drive == 2'h3);
endmodule
`default_nettype wire

// *** verification/float_mode_pulse_config_tb_top.sv ***
// Self-checking testbench for the float-mode pulse configuration register bank.
`timescale 1ns/1ns
`default_nettype none
`include "float_cfg_params.svh"
`define CHK(a, b, m) begin samples_checked++; if ((a) !== (b)) begin n_mismatch++; $display("CHECK FAILED %0t %s", $time, m); end end
module float_mode_pulse_config_tb_top;
	// One microsecond of pulse width is this many 40 ns clock cycles.
	localparam int TICKS = 1000 / 40;
	logic clock;
	logic sys_rst;
	logic [7:0] reg_addr;
	logic [15:0] reg_wdata;
	logic reg_wr;
	logic reg_rd;
	logic [15:0] reg_rdata;
	logic reg_rvalid;
	logic [1:0] slot_start;
	logic [1:0] pulse_req;
	logic [4:0] width_a;
	logic [4:0] width_b;
	logic [3:0] pair_a;
	logic [3:0] pair_b;
	logic float_active_a;
	logic float_active_b;
	logic [4:0] precon_a;
	logic [4:0] precon_b;
	logic [1:0] led_drive;
	logic [1:0] sample_subtract;
	int n_mismatch = 0;
	int samples_checked = 0;
	logic [3:0] pat [2] = '{4'h5, 4'h6};
	logic [3:0] code [2] = '{4'h6, 4'h9};
	int len [2] = '{TICKS, 2 * TICKS};

	float_mode_pulse_config uut (.clock(clock), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .slot_start(slot_start),
		.pulse_req(pulse_req), .float_pulse_width_slot_a(width_a), .float_pulse_width_slot_b(width_b),
		.pair_sum_control_slot_a(pair_a), .pair_sum_control_slot_b(pair_b), .float_active_a(float_active_a),
		.float_active_b(float_active_b), .precondition_delay_slot_a(precon_a), .precondition_delay_slot_b(precon_b),
		.led_drive(led_drive), .sample_subtract(sample_subtract));

	// Free-running 25 MHz clock.
	always #20 clock = ~clock;

	// Single place where the run ends.
	task automatic complete_run();
		if (n_mismatch == 0 && samples_checked > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask

	// Strobes last exactly one cycle, so a write and the next access always have an idle edge between them.
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		@(posedge clock);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clock);
		reg_wr <= 1'b0;
	endtask

	// Read answer is fixed at one cycle after the strobe edge.
	task automatic rd(input logic [7:0] a, input logic [15:0] e);
		@(posedge clock);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clock);
		reg_rd <= 1'b0;
		#1;
		`CHK(reg_rvalid, 1'b1, "read valid missing")
		`CHK(reg_rdata, e, "read data")
	endtask

	task automatic do_reset();
		@(posedge clock);
		sys_rst <= 1'b1;
		repeat (3) @(posedge clock);
		sys_rst <= 1'b0;
		rd(`ADDR_FLOAT_CFG_B, 16'h0808);
		rd(`ADDR_FIRE_MASKS, 16'h0010);
		rd(`ADDR_FLOAT_CFG_A, 16'h0808);
		`CHK({precon_a, precon_b}, 10'h108, "precondition default")
		`CHK({float_active_a, float_active_b}, 2'h0, "float off at reset")
	endtask

	// Issues one pulse request; the length of the lit LED is counted under a bound.
	task automatic pulse(input int s, input logic fire, input logic sub);
		int n;
		n = 0;
		@(posedge clock);
		pulse_req[s] <= 1'b1;
		@(posedge clock);
		pulse_req[s] <= 1'b0;
		#1;
		`CHK(led_drive[s], fire, "led fire decision")
		`CHK(sample_subtract[s], sub, "sample sign")
		while (led_drive[s] === 1'b1 && n < 200) begin
			@(posedge clock);
			#1;
			n++;
		end
		if (n >= 200) begin
			n_mismatch++;
			complete_run();
		end
		`CHK(n, fire ? len[s] : 0, "pulse length")
	endtask

	// Main sequence.
	initial begin
		clock = 1'b0;
		sys_rst = 1'b1;
		reg_addr = 8'h00;
		reg_wdata = 16'h0000;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		slot_start = 2'h0;
		pulse_req = 2'h0;
		width_a = 5'h01;
		width_b = 5'h02;
		pair_a = code[0];
		pair_b = code[1];
		do_reset();
		// Every enable code, including the reserved ones, with a distinct delay per slot.
		for (int c = 0; c < 4; c++) begin
			wr(`ADDR_FLOAT_CFG_A, {1'b0, 2'(c), 5'h0A, 8'h08});
			wr(`ADDR_FLOAT_CFG_B, {1'b0, 2'(c), 5'h11, 8'h08});
			rd(`ADDR_FLOAT_CFG_B, {1'b0, 2'(c), 5'h11, 8'h08});
			`CHK(float_active_a, (c == 3), "slot A float enable")
			`CHK(float_active_b, (c == 3), "slot B float enable")
			`CHK({precon_a, precon_b}, 10'h151, "precondition fields")
			rd(`ADDR_FLOAT_CFG_A, {1'b0, 2'(c), 5'h0A, 8'h08});
		end
		// Restore the typical preconditioning delay with float mode on in both slots.
		wr(`ADDR_FLOAT_CFG_A, 16'h6808);
		wr(`ADDR_FLOAT_CFG_B, 16'h6808);
		rd(`ADDR_FLOAT_CFG_B, 16'h6808);
		`CHK({float_active_a, float_active_b, precon_a, precon_b}, 12'hD08, "typical delay restored")
		// An unmapped write must not disturb its neighbours.
		wr(`ADDR_FIRE_MASKS, {pat[1], pat[0], 8'h10});
		wr(8'h5B, 16'hFFFF);
		rd(8'h5B, 16'h0000);
		rd(`ADDR_FIRE_MASKS, {pat[1], pat[0], 8'h10});
		// Six pulses per slot wrap the group once, then a slot start returns to the first position.
		for (int s = 0; s < 2; s++) begin
			for (int k = 0; k < 6; k++) pulse(s, ~pat[s][k % 4], code[s][(k % 4) ^ 1]);
			@(posedge clock);
			slot_start[s] <= 1'b1;
			@(posedge clock);
			slot_start[s] <= 1'b0;
			pulse(s, ~pat[s][0], code[s][1]);
		end
		// A second reset in mid-run restores every default.
		do_reset();
		complete_run();
	end

	// Hang guard.
	initial begin
		#2000000;
		n_mismatch++;
		complete_run();
	end
endmodule
`default_nettype wire
